// ==== logic/ptc_pkg.sv ====
// shared constants, register map and carrier types of the post-trim clamp and coil diagnostics
package ptc_pkg;
    // register indices (byte address = 4 * index)
    localparam logic [5:0]  IDX_LIMIT  = 6'h08;
    localparam logic [5:0]  IDX_CFG    = 6'h09;
    localparam logic [5:0]  IDX_TRIM   = 6'h13;
    localparam logic [5:0]  IDX_STATUS = 6'h14;
    localparam int          AXI_AW     = 8;

    // field positions
    localparam int GAIN_LSB   = 0;
    localparam int QVO_LSB    = 12;
    localparam int UPPER_LSB  = 0;
    localparam int LOWER_LSB  = 12;
    localparam int CFG_EN_LSB = 0;
    localparam int CFG_DMODE  = 5;
    localparam int CFG_CBDIS  = 6;
    localparam int CFG_CCDIS  = 7;
    localparam int CFG_STREQ  = 8;
    localparam int CFG_FQ_LSB = 13;
    localparam int ST_CERR    = 0;
    localparam int ST_SMP_LSB = 16;

    // reset values
    localparam logic [23:0] LIMIT_RST = 24'h000fff;
    localparam logic [23:0] TRIM_RST  = 24'h000000;
    localparam logic [23:0] CFG_RST   = 24'h00001f;

    // arithmetic constants
    localparam logic signed [15:0] SAT_MAX   = 16'sh07ff;
    localparam logic signed [15:0] SAT_MIN   = -16'sh0800;
    localparam int                 GAIN_SHIFT = 11;
    localparam logic [15:0]        DEV_SCALE = 16'h000a;
    localparam logic [1:0]         FQ_NONE   = 2'h3;
    localparam logic [1:0]         FQ_SHORT  = 2'h1;
    localparam logic [1:0]         FQ_LONG   = 2'h2;
    localparam logic [1:0]         RESP_OK   = 2'h0;
    localparam logic [1:0]         RESP_ERR  = 2'h2;

    // timing
    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned SAMPLE_HZ   = 16_000;
    localparam int unsigned PATH_HZ     = 128_000;
    localparam int unsigned CHECK_HZ    = 8_000;
    localparam int unsigned COIL_ON_MS  = 16;
    localparam int unsigned OFF_SHORT_MS = 16;
    localparam int unsigned OFF_LONG_MS = 4080;
    localparam int unsigned SAMPLE_CYC  = CLK_HZ / SAMPLE_HZ;
    localparam int unsigned PATH_CYC    = CLK_HZ / PATH_HZ;
    localparam int unsigned CHECK_CYC   = CLK_HZ / CHECK_HZ;
    localparam int unsigned COIL_ON_CYC = COIL_ON_MS * (CLK_HZ / 1000);
    localparam int unsigned OFF_SHORT_CYC = OFF_SHORT_MS * (CLK_HZ / 1000);
    localparam int unsigned OFF_LONG_CYC  = OFF_LONG_MS * (CLK_HZ / 1000);

    typedef enum logic [1:0] {
        COIL_IDLE = 2'b00,
        COIL_ON   = 2'b01,
        COIL_OFF  = 2'b10
    } ptc_coil_t;

    // detector inputs from the analog and self-test monitors
    typedef struct packed {
        logic sig_range;
        logic bist_fail;
        logic under_volt;
        logic over_volt;
    } ptc_det_t;
endpackage : ptc_pkg

// ==== logic/ptc_core.sv ====
// post-linearization trim, clamp, sample pacing and coil self-check with AXI4-Lite registers
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
// How it works
// - trimmed value is linearized value times one plus gain, plus offset.
// - gain trim is bits 11:0, signed, step two to minus eleven.
// - offset trim is bits 23:12, signed, unit step, -2048 to +2047.
// - trimmed value is a 12-bit signed integer, saturated to -2048 to +2047.
// - clamp input becomes unsigned by adding 2048, range 0 to 4095.
// - above upper gives upper, below lower gives lower, else value passes.
// - limit word holds upper in bits 11:0, lower in bits 23:12.
// - clamped unsigned sample goes to the output block at 16 kHz.
// - diagnostic word enables five error kinds: OV, UV, self-test, range, coil.
// - errors flag the message by default, or tristate output when selected.
// - rate selection below 3 drives the coil to inject a diagnostic field.
// - analog path alternates diagnostic and external input at about 128 kHz while the coil is driven.
// - coil response checked at 8 kHz; deviation over 10% forces error.
// - coil report mask set suppresses coil error reporting on the output.
// - drift compensation disable turns compensation off, keeps coil diagnostics.
// - coil on-phase 16 ms; off-phase 0, 16 or 4080 ms for rates 0-2.
// - rate 3 stops coil in normal use; results only after self-test request.
// - trim input is the 13-bit signed linearization result.
module ptc_core
    import ptc_pkg::*;
#(
    parameter int unsigned COIL_ON_CYCLES   = COIL_ON_CYC,
    parameter int unsigned OFF_SHORT_CYCLES = OFF_SHORT_CYC,
    parameter int unsigned OFF_LONG_CYCLES  = OFF_LONG_CYC,
    parameter logic [11:0] COIL_REF         = 12'h800
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
    input  wire logic [2:0]          s_axi_awprot,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [AXI_AW-1:0]   s_axi_araddr,
    input  wire logic [2:0]          s_axi_arprot,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic signed [12:0]  linearized_value,
    input  wire logic [11:0]         coil_response,
    input  wire ptc_det_t            detect,
    output logic [11:0]              sample_out,
    output logic                     sample_valid,
    output logic                     diag_err_flag,
    output logic                     out_hiz,
    output logic                     coil_drive,
    output logic                     path_diag_sel,
    output logic                     drift_comp_en
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////////////
    // register bus
    logic              aw_got, next_aw_got, w_got, next_w_got;
    logic [5:0]        aw_idx, next_aw_idx;
    logic [31:0]       w_data, next_w_data;
    logic [3:0]        w_strb, next_w_strb;
    logic              next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0]        next_bresp, next_rresp;
    logic [31:0]       next_rdata;
    logic [23:0]       limit_word, next_limit_word;
    logic [23:0]       trim_word, next_trim_word;
    logic [23:0]       cfg_word, next_cfg_word;
    logic              st_req, next_st_req;
    logic              coil_err, next_coil_err;
    logic              coil_fail;
    logic              do_write;

    function automatic logic [23:0] merge(input logic [23:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [23:0] r;
        r = old;
        for (int b = 0; b < 3; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    always_comb begin
        next_aw_got     = aw_got;
        next_aw_idx     = aw_idx;
        next_w_got      = w_got;
        next_w_data     = w_data;
        next_w_strb     = w_strb;
        next_bvalid     = s_axi_bvalid;
        next_bresp      = s_axi_bresp;
        next_arready    = 1'b0;
        next_rvalid     = s_axi_rvalid;
        next_rresp      = s_axi_rresp;
        next_rdata      = s_axi_rdata;
        next_limit_word = limit_word;
        next_trim_word  = trim_word;
        next_cfg_word   = cfg_word;
        next_st_req     = 1'b0;
        next_coil_err   = coil_err;
        do_write        = aw_got && w_got && !s_axi_bvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_got = 1'b1;
            next_aw_idx = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_got  = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_got = 1'b0;
            next_w_got  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = RESP_OK;
            if (aw_idx == IDX_LIMIT) begin
                next_limit_word = merge(limit_word, w_data, w_strb);
            end else if (aw_idx == IDX_TRIM) begin
                next_trim_word = merge(trim_word, w_data, w_strb);
            end else if (aw_idx == IDX_CFG) begin
                next_cfg_word = merge(cfg_word, w_data, w_strb);
                next_cfg_word[CFG_STREQ] = 1'b0;
                next_st_req = w_strb[1] && w_data[CFG_STREQ];
            end else if (aw_idx == IDX_STATUS) begin
                if (w_strb[0] && w_data[ST_CERR]) begin
                    next_coil_err = 1'b0;
                end
            end else begin
                next_bresp = RESP_ERR;
            end
        end
        // a failure in the clearing cycle must not be lost
        if (coil_fail) begin
            next_coil_err = 1'b1;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OK;
            next_rdata  = 32'h0000_0000;
            if (s_axi_araddr[7:2] == IDX_LIMIT) begin
                next_rdata[23:0] = limit_word;
            end else if (s_axi_araddr[7:2] == IDX_TRIM) begin
                next_rdata[23:0] = trim_word;
            end else if (s_axi_araddr[7:2] == IDX_CFG) begin
                next_rdata[23:0] = cfg_word;
            end else if (s_axi_araddr[7:2] == IDX_STATUS) begin
                next_rdata[ST_CERR]              = coil_err;
                next_rdata[1]                    = coil_drive;
                next_rdata[2]                    = diag_err_flag || out_hiz;
                next_rdata[ST_SMP_LSB +: 12]     = sample_out;
            end else begin
                next_rresp = RESP_ERR;
            end
        end else if (!next_rvalid && !s_axi_arready) begin
            next_arready = 1'b1;
        end
        next_awready = !next_aw_got && !next_bvalid;
        next_wready  = !next_w_got && !next_bvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got        <= 1'b0;
            aw_idx        <= 6'h00;
            w_got         <= 1'b0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OK;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= RESP_OK;
            s_axi_rdata   <= 32'h0000_0000;
            limit_word    <= LIMIT_RST;
            trim_word     <= TRIM_RST;
            cfg_word      <= CFG_RST;
            st_req        <= 1'b0;
            coil_err      <= 1'b0;
        end else begin
            aw_got        <= next_aw_got;
            aw_idx        <= next_aw_idx;
            w_got         <= next_w_got;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rresp   <= next_rresp;
            s_axi_rdata   <= next_rdata;
            limit_word    <= next_limit_word;
            trim_word     <= next_trim_word;
            cfg_word      <= next_cfg_word;
            st_req        <= next_st_req;
            coil_err      <= next_coil_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // trim, clamp and sample pacing
    logic signed [11:0] gain, qvo, trimmed;
    logic signed [24:0] prod;
    logic signed [15:0] wide;
    logic [11:0]        upper, lower, unsigned_val, clamped, next_sample_out;
    logic [9:0]         samp_cnt, next_samp_cnt;
    logic               samp_tick, next_sample_valid, clamp_hit;

    always_comb begin
        gain  = signed'(trim_word[GAIN_LSB +: 12]);
        qvo   = signed'(trim_word[QVO_LSB +: 12]);
        upper = limit_word[UPPER_LSB +: 12];
        lower = limit_word[LOWER_LSB +: 12];
        // y * (1 + g/2048) = y + (y*g >>> 11), so the 13-bit input keeps full precision
        prod  = linearized_value * gain;
        wide  = 16'(linearized_value) + 16'(prod >>> GAIN_SHIFT) + 16'(qvo);
        if (wide > SAT_MAX) begin
            trimmed = SAT_MAX[11:0];
        end else if (wide < SAT_MIN) begin
            trimmed = SAT_MIN[11:0];
        end else begin
            trimmed = wide[11:0];
        end
        unsigned_val = {~trimmed[11], trimmed[10:0]};
        // limits crossed over are left to software; upper then wins
        if (unsigned_val > upper) begin
            clamped = upper;
        end else if (unsigned_val < lower) begin
            clamped = lower;
        end else begin
            clamped = unsigned_val;
        end
        clamp_hit         = (unsigned_val > upper) || (unsigned_val < lower);
        samp_tick         = (samp_cnt == 10'(SAMPLE_CYC - 1));
        next_samp_cnt     = samp_tick ? 10'h000 : samp_cnt + 10'h001;
        next_sample_valid = samp_tick;
        next_sample_out   = samp_tick ? clamped : sample_out;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            samp_cnt     <= 10'h000;
            sample_valid <= 1'b0;
            sample_out   <= 12'h000;
        end else begin
            samp_cnt     <= next_samp_cnt;
            sample_valid <= next_sample_valid;
            sample_out   <= next_sample_out;
        end
    end

    AST_SAMPLE_RATE: assert property (sample_valid |=> !sample_valid [*8] ##[617:617] sample_valid)
        else $error("sample spacing is not the output rate");
    AST_CLAMP_HIGH: assert property ($past(samp_tick) && $past(unsigned_val) > $past(upper)
        |-> sample_out == $past(upper))
        else $error("value above upper limit not clamped");
    AST_CLAMP_LOW: assert property ($past(samp_tick) && $past(unsigned_val) < $past(lower)
        && $past(lower) <= $past(upper) |-> sample_out == $past(lower))
        else $error("value below lower limit not clamped");
    AST_OFFSET_SHIFT: assert property (samp_tick && unsigned_val >= lower && unsigned_val <= upper
        |=> sample_out == {~$past(trimmed[11]), $past(trimmed[10:0])})
        else $error("in-range sample is not trimmed value plus 2048");
    AST_SATURATE: assert property (wide > SAT_MAX |-> trimmed == 12'h7ff)
        else $error("overflowing trim result wrapped");

    ////////////////////////////////////////////////////////////////////////////////
    // coil scheduler, path sharing, coil check and error reporting
    ptc_coil_t   coil_state, next_coil_state;
    logic [31:0] coil_cnt, next_coil_cnt;
    logic [6:0]  path_cnt, next_path_cnt;
    logic [10:0] chk_cnt, next_chk_cnt;
    logic        st_run, next_st_run;
    logic        next_coil_drive, next_path_sel, next_drift, next_flag, next_hiz;
    logic [1:0]  freq;
    logic [4:0]  en;
    logic        any_err;
    logic [15:0] dev;

    always_comb begin
        freq            = cfg_word[CFG_FQ_LSB +: 2];
        en              = cfg_word[CFG_EN_LSB +: 5];
        next_coil_state = coil_state;
        next_coil_cnt   = coil_cnt + 32'h1;
        next_st_run     = st_run;
        case (coil_state)
            COIL_IDLE: begin
                next_coil_cnt = 32'h0;
                if (freq != FQ_NONE || st_req) begin
                    next_coil_state = COIL_ON;
                    next_st_run     = (freq == FQ_NONE);
                end
            end
            COIL_ON: begin
                if (coil_cnt == COIL_ON_CYCLES - 1) begin
                    next_coil_cnt = 32'h0;
                    if (st_run || freq == FQ_NONE) begin
                        next_coil_state = COIL_IDLE;
                        next_st_run     = 1'b0;
                    end else if (freq != 2'h0) begin
                        next_coil_state = COIL_OFF;
                    end
                end
            end
            COIL_OFF: begin
                if (freq == FQ_NONE) begin
                    next_coil_state = COIL_IDLE;
                end else if ((freq == FQ_SHORT && coil_cnt >= OFF_SHORT_CYCLES - 1) ||
                             (freq == FQ_LONG && coil_cnt >= OFF_LONG_CYCLES - 1)) begin
                    next_coil_state = COIL_ON;
                    next_coil_cnt   = 32'h0;
                end
            end
            default: begin
                next_coil_state = COIL_IDLE;
            end
        endcase
        next_coil_drive = (next_coil_state == COIL_ON);
        // path sharing only while the coil injects; else the external field owns the path
        next_path_cnt = (coil_drive && path_cnt != 7'(PATH_CYC - 1)) ? path_cnt + 7'h01 : 7'h00;
        next_path_sel = coil_drive && (path_cnt == 7'(PATH_CYC - 1) ? !path_diag_sel
                                                                   : path_diag_sel);
        next_drift    = next_coil_drive && !cfg_word[CFG_CCDIS];
        next_chk_cnt  = (coil_drive && chk_cnt != 11'(CHECK_CYC - 1)) ? chk_cnt + 11'h001
                                                                    : 11'h000;
        dev           = (coil_response > COIL_REF) ? 16'(coil_response - COIL_REF)
                                                   : 16'(COIL_REF - coil_response);
        // deviation * 10 > ref is the 10% test without a divider
        coil_fail = coil_drive && chk_cnt == 11'(CHECK_CYC - 1)
                    && (dev * DEV_SCALE > 16'(COIL_REF));
        any_err = (detect.over_volt && en[0]) || (detect.under_volt && en[1]) ||
                  (detect.bist_fail && en[2]) || ((detect.sig_range || clamp_hit) && en[3]) ||
                  (coil_err && en[4] && !cfg_word[CFG_CBDIS]);
        next_flag = any_err && !cfg_word[CFG_DMODE];
        next_hiz  = any_err && cfg_word[CFG_DMODE];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            coil_state    <= COIL_IDLE;
            coil_cnt      <= 32'h0;
            path_cnt      <= 7'h00;
            chk_cnt       <= 11'h000;
            st_run        <= 1'b0;
            coil_drive    <= 1'b0;
            path_diag_sel <= 1'b0;
            drift_comp_en <= 1'b0;
            diag_err_flag <= 1'b0;
            out_hiz       <= 1'b0;
        end else begin
            coil_state    <= next_coil_state;
            coil_cnt      <= next_coil_cnt;
            path_cnt      <= next_path_cnt;
            chk_cnt       <= next_chk_cnt;
            st_run        <= next_st_run;
            coil_drive    <= next_coil_drive;
            path_diag_sel <= next_path_sel;
            drift_comp_en <= next_drift;
            diag_err_flag <= next_flag;
            out_hiz       <= next_hiz;
        end
    end

    AST_COIL_IDLE3: assert property (coil_state == COIL_IDLE && freq == FQ_NONE && !st_req
        |=> !coil_drive)
        else $error("coil driven with rate 3 and no self-test");
    AST_PATH_TOGGLE: assert property ($rose(path_diag_sel) |-> ##78 (!path_diag_sel || !coil_drive))
        else $error("path sharing period wrong");
    AST_DRIFT_OFF: assert property (cfg_word[CFG_CCDIS] |=> !drift_comp_en)
        else $error("drift compensation on while disabled");
    AST_FLAG_MODE: assert property (any_err && !cfg_word[CFG_DMODE] |=> diag_err_flag && !out_hiz)
        else $error("error not flagged in message mode");
    AST_HIZ_MODE: assert property (any_err && cfg_word[CFG_DMODE] |=> out_hiz && !diag_err_flag)
        else $error("error not tristated in high impedance mode");
    AST_COIL_MASK: assert property (cfg_word[CFG_CBDIS] && !detect.over_volt && !detect.under_volt
        && !detect.bist_fail && !detect.sig_range && !clamp_hit |=> !diag_err_flag && !out_hiz)
        else $error("masked coil error still reported");
    AST_COIL_STICKY: assert property (coil_fail |=> coil_err)
        else $error("coil failure lost");
endmodule : ptc_core

// ==== tb/ptc_sink.sv ====
// sample sink standing in for the output protocol block
`timescale 1ns/1ps
module ptc_sink
    import ptc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        sample_valid,
    input  wire logic [11:0] sample_out,
    output logic [11:0]      last,
    output int               gap_err
);
    int   cnt;
    logic seen;
    // the gap is only judged between two pulses, the first has no reference
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= 0;
            seen <= 1'b0;
            gap_err <= 0;
            last <= 12'h000;
        end else begin
            cnt <= cnt + 1;
            if (sample_valid) begin
                last <= sample_out;
                cnt <= 1;
                seen <= 1'b1;
                if (seen && cnt != SAMPLE_CYC) gap_err <= gap_err + 1;
            end
        end
    end
endmodule : ptc_sink

// ==== tb/tb_top.sv ====
// testbench for the post-trim clamp and coil diagnostics
`timescale 1ns/1ps
module tb_top
    import ptc_pkg::*;
;
    localparam logic [7:0] A_LIM = {IDX_LIMIT, 2'b00};
    localparam logic [7:0] A_CFG = {IDX_CFG, 2'b00};
    localparam logic [7:0] A_TRM = {IDX_TRIM, 2'b00};
    localparam logic [7:0] A_ST  = {IDX_STATUS, 2'b00};
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic awr, wrdy, bv, arr, rv, sv, derr, hiz, cdrv, psel, dce;
    logic [7:0] awa = 0, ara = 0;
    logic [3:0] ws = 4'hf;
    logic [31:0] wd = 0, rdat;
    logic [1:0] br, rr;
    logic signed [12:0] lin = 0;
    logic [11:0] cres = 12'h800, so, last;
    ptc_det_t det = 4'h0;
    int bad_count = 0, compares = 0, gap_err;
    ptc_core #(.COIL_ON_CYCLES(200), .OFF_SHORT_CYCLES(200), .OFF_LONG_CYCLES(500)) uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .linearized_value(lin), .coil_response(cres), .detect(det),
        .sample_out(so), .sample_valid(sv), .diag_err_flag(derr), .out_hiz(hiz),
        .coil_drive(cdrv), .path_diag_sel(psel), .drift_comp_en(dce));
    ptc_sink snk (.aclk(aclk), .aresetn(aresetn), .sample_valid(sv), .sample_out(so),
        .last(last), .gap_err(gap_err));
    initial forever #50 aclk = ~aclk;
////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            $display("MISMATCH %s exp %h got %h", n, e, s);
            bad_count++;
        end
    endtask : chk
    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task automatic tmo(input logic ok);
        if (!ok) begin
            $display("MISMATCH wait exp 1 got 0");
            bad_count++;
            summarize();
        end
    endtask : tmo
    task automatic wt(ref logic s, input logic v, input int lim);
        for (int n = 0; n < lim && s !== v; n++) @(posedge aclk);
        tmo(s === v);
    endtask : wt
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n = 0;
        awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (awr) awv <= 0;
            if (wrdy) wv <= 0;
        end while (bv !== 1'b1 && n < 50);
        tmo(bv === 1'b1);
        bre <= 0;
        chk("bresp", e, br);
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n = 0;
        ara <= a; arv <= 1; rre <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (arr) arv <= 0;
        end while (rv !== 1'b1 && n < 50);
        tmo(rv === 1'b1);
        rre <= 0;
        chk("rresp", er, rr);
        chk("rdata", e, rdat);
        @(posedge aclk);
    endtask : rd
////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd(A_LIM, 32'h000fff, RESP_OK);
        rd(A_CFG, 32'h1f, RESP_OK);
        wr(A_TRM, 32'hff123456, RESP_OK);
        rd(A_TRM, 32'h123456, RESP_OK);
        ws <= 4'h1;
        wr(A_TRM, 32'h0, RESP_OK);
        ws <= 4'hf;
        rd(A_TRM, 32'h123400, RESP_OK);
        rd(8'h00, 0, RESP_ERR);
        wr(8'h00, 32'hffffffff, RESP_ERR);
        $display("test regs done");
    endtask : t_regs
    task automatic t_diag;
        det <= 4'h1;
        repeat (3) @(posedge aclk);
        chk("err", 1, derr);
        wr(A_CFG, 32'h1e, RESP_OK);
        repeat (2) @(posedge aclk);
        chk("err", 0, derr);
        wr(A_CFG, 32'h3f, RESP_OK);
        repeat (2) @(posedge aclk);
        chk("hiz", 1, hiz);
        chk("err", 0, derr);
        det <= 4'h0;
        wr(A_CFG, 32'h1f, RESP_OK);
        $display("test diag done");
    endtask : t_diag
    task automatic t_clamp;
        logic signed [12:0] lv[5] = '{13'sd600, 13'sd2000, 13'sd600, -13'sd2000, 13'sd1000};
        logic [23:0] tr[5] = '{24'h064400, 24'h064400, 24'h064400, 24'h0, 24'hfffc00};
        logic [23:0] lm[5] = '{24'h000fff, 24'h000fff, 24'h300900, 24'h300900, 24'h000fff};
        logic [11:0] ex[5] = '{12'hbe8, 12'hfff, 12'h900, 12'h300, 12'h9f3};
        for (int i = 0; i < 5; i++) begin
            wr(A_LIM, {8'h00, lm[i]}, RESP_OK);
            wr(A_TRM, {8'h00, tr[i]}, RESP_OK);
            lin <= lv[i];
            wt(sv, 1, 700);
            @(posedge aclk);
            wt(sv, 1, 700);
            @(posedge aclk);
            chk("sample", {20'h0, ex[i]}, {20'h0, so});
            chk("sink", {20'h0, ex[i]}, {20'h0, last});
        end
        chk("gap", 0, gap_err);
        $display("test clamp done");
    endtask : t_clamp
    task automatic t_coil;
        chk("coil", 1, cdrv);
        chk("comp", 1, dce);
        wt(psel, ~psel, 100);
        cres <= 12'h600;
        wt(derr, 1, 2600);
        rd(A_ST, 32'h09f30007, RESP_OK);
        wr(A_CFG, 32'h5f, RESP_OK);
        repeat (2) @(posedge aclk);
        chk("err", 0, derr);
        wr(A_CFG, 32'h9f, RESP_OK);
        repeat (2) @(posedge aclk);
        chk("comp", 0, dce);
        chk("coil", 1, cdrv);
        cres <= 12'h800;
        wr(A_ST, 32'h1, RESP_OK);
        wr(A_CFG, 32'h601f, RESP_OK);
        wt(cdrv, 0, 300);
        chk("err", 0, derr);
        wr(A_CFG, 32'h611f, RESP_OK);
        wt(cdrv, 1, 10);
        wt(cdrv, 0, 300);
        wr(A_CFG, 32'h201f, RESP_OK);
        wt(cdrv, 0, 300);
        wt(cdrv, 1, 300);
        wr(A_CFG, 32'h401f, RESP_OK);
        wt(cdrv, 0, 300);
        repeat (300) @(posedge aclk);
        chk("coil", 0, cdrv);
        wt(cdrv, 1, 300);
        $display("test coil done");
    endtask : t_coil
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_regs();
        t_diag();
        t_clamp();
        t_coil();
        summarize();
    end
endmodule : tb_top
